/* core/amp_ref_config.sv */
// Amplifier factor, bypass, reference selection and fault flags
// Behaviour
// [R1] Eight amplifier factors 1 to 128 from a three-bit field.
// [R2] Factor code n means a factor of two to the power n.
// [R3] Enable field 00 powers down and bypasses; 01 enables the amplifier.
// [R4] Software never writes the reserved enable codes 10 or 11.
// [R5] Factors 64 and 128 run analog at 32, rest as digital scaling.
// [R6] Four rail flags, one per output polarity and rail, within 150 mV.
// [R7] Rail detection works only while the detect enable bit is set.
// [R8] Software bypasses the amplifier only at unity factor.
// [R9] Single-ended inputs against negative supply need the amplifier bypassed.
// [R10] Two-bit reference select; reset picks external pair zero.
// [R11] Select code 10 routes the internal reference to the converter.
// [R12] Power 10 always on, 01 sleeps in power-down; reset powers off.
// [R13] Software powers the internal reference while excitation sources run.
// [R14] Software waits 4.5 to 7.0 ms reference start-up before converting.
// [R15] Low reference checked each conversion; one flag per external pair.
`timescale 1ns/1ps
module amp_ref_config
	import amp_ref_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Register port
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	output logic            reg_rvalid,
	// Analog monitors
	input  wire logic [3:0] rail_near,
	input  wire logic [1:0] vref_pair_low,
	input  wire logic       conversion_active,
	input  wire logic       power_down,
	// Amplifier control
	output logic            amp_powered,
	output logic            amp_bypass,
	output logic      [7:0] amp_factor,
	output logic      [2:0] amp_analog_code,
	output logic      [1:0] amp_digital_shift,
	output logic            rail_detect_on,
	// Reference control
	output logic      [1:0] vref_source_select,
	output logic            internal_vref_routed,
	output logic            internal_vref_on
);
	logic [7:0] amp_setting_q;
	logic [7:0] reference_control_q;
	logic [7:0] excitation_current_one_q;
	logic [7:0] rdata_q;
	logic       rvalid_q;
	logic       powered_q;
	logic       bypass_q;
	logic [7:0] factor_q;
	logic [2:0] analog_q;
	logic [1:0] shift_q;
	logic       rail_det_q;
	logic [1:0] vsel_q;
	logic       vroute_q;
	logic       von_q;

	logic [2:0] factor_code;
	logic [1:0] amp_power_bypass_field;
	logic [1:0] internal_vref_power;
	logic       rail_detect_enable;
	logic       status_wr;
	logic [7:0] fault_status;

	flag_if #(.W(RAIL_FLAGS)) rail_bus ();
	flag_if #(.W(VREF_FLAGS)) vref_bus ();

	assign factor_code            = amp_setting_q[AMP_FACTOR_LSB +: 3];
	assign amp_power_bypass_field = amp_setting_q[AMP_EN_LSB +: 2];
	assign internal_vref_power    = reference_control_q[VREF_POWER_LSB +: 2];
	assign rail_detect_enable     = excitation_current_one_q[RAIL_DET_BIT];
	assign status_wr              = reg_wr && (reg_addr == OFF_FAULT_STATUS);

	// ==========================================================
	// Configuration registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			amp_setting_q            <= RST_AMP_SETTING;
			reference_control_q      <= RST_REFERENCE_CTRL;
			excitation_current_one_q <= RST_EXCITATION_ONE;
		end else if (reg_wr) begin
			unique case (reg_addr)
				OFF_AMP_SETTING:    amp_setting_q            <= reg_wdata;
				OFF_REFERENCE_CTRL: reference_control_q      <= reg_wdata;
				OFF_EXCITATION_ONE: excitation_current_one_q <= reg_wdata;
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// Fault flags
	// [R7] gated rail detection
	assign rail_bus.set = rail_near & {RAIL_FLAGS{rail_detect_enable}};
	assign rail_bus.clr = status_wr ? reg_wdata[RAIL_FLAG_LSB +: RAIL_FLAGS] : '0;
	// [R15] checked per conversion
	assign vref_bus.set = vref_pair_low & {VREF_FLAGS{conversion_active}};
	assign vref_bus.clr = status_wr ? reg_wdata[VREF_FLAG_LSB +: VREF_FLAGS] : '0;

	sticky_flags #(.W(RAIL_FLAGS)) u_rail_flags (
		.clk  (clk),
		.rst  (rst),
		.port (rail_bus.keeper)
	);
	sticky_flags #(.W(VREF_FLAGS)) u_vref_flags (
		.clk  (clk),
		.rst  (rst),
		.port (vref_bus.keeper)
	);

	// [R6] status layout
	assign fault_status = {2'h0, rail_bus.flags, vref_bus.flags};

	// ==========================================================
	// Register read port
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= reg_rd;
			if (reg_rd) begin
				unique case (reg_addr)
					OFF_FAULT_STATUS:   rdata_q <= fault_status;
					OFF_AMP_SETTING:    rdata_q <= amp_setting_q;
					OFF_REFERENCE_CTRL: rdata_q <= reference_control_q;
					OFF_EXCITATION_ONE: rdata_q <= excitation_current_one_q;
					default:            rdata_q <= 8'h00;
				endcase
			end
		end
	end

	// ==========================================================
	// Amplifier decode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			powered_q  <= 1'b0;
			bypass_q   <= 1'b1;
			factor_q   <= 8'h01;
			analog_q   <= 3'h0;
			shift_q    <= 2'h0;
			rail_det_q <= 1'b0;
		end else begin
			// [R3] enable or bypass
			powered_q  <= (amp_power_bypass_field == AMP_EN_ON);
			bypass_q   <= (amp_power_bypass_field != AMP_EN_ON);
			// [R1] [R2] power of two
			factor_q   <= 8'h01 << factor_code;
			// [R5] analog capped at 32
			if ((amp_power_bypass_field == AMP_EN_ON) && (factor_code > AMP_ANALOG_MAX_CODE)) begin
				analog_q <= AMP_ANALOG_MAX_CODE;
				shift_q  <= 2'(factor_code - AMP_ANALOG_MAX_CODE);
			end else begin
				analog_q <= factor_code;
				shift_q  <= 2'h0;
			end
			rail_det_q <= rail_detect_enable;
		end
	end

	// ==========================================================
	// Reference decode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			vsel_q   <= VREF_SEL_PAIR0;
			vroute_q <= 1'b0;
			von_q    <= 1'b0;
		end else begin
			// [R10] source select
			vsel_q   <= reference_control_q[VREF_SEL_LSB +: 2];
			// [R11] internal routing
			vroute_q <= (reference_control_q[VREF_SEL_LSB +: 2] == VREF_SEL_INTERNAL);
			// [R12] power modes
			von_q    <= (internal_vref_power == VREF_PWR_ALWAYS) ||
			            ((internal_vref_power == VREF_PWR_SLEEPS) && !power_down);
		end
	end

	assign reg_rdata            = rdata_q;
	assign reg_rvalid           = rvalid_q;
	assign amp_powered          = powered_q;
	assign amp_bypass           = bypass_q;
	assign amp_factor           = factor_q;
	assign amp_analog_code      = analog_q;
	assign amp_digital_shift    = shift_q;
	assign rail_detect_on       = rail_det_q;
	assign vref_source_select   = vsel_q;
	assign internal_vref_routed = vroute_q;
	assign internal_vref_on     = von_q;

	// ==========================================================
	// Checks
	property p_factor_pow2;
		@(posedge clk) disable iff (rst)
		##1 (amp_factor == (8'h01 << $past(factor_code)));
	endproperty
	a_factor_pow2: assert property (p_factor_pow2) // [R2]
		else $error("factor is not two to the code");

	property p_bypass;
		@(posedge clk) disable iff (rst)
		(amp_power_bypass_field == AMP_EN_BYPASS) |=> (amp_bypass && !amp_powered);
	endproperty
	a_bypass: assert property (p_bypass) // [R3]
		else $error("amplifier not bypassed on code 00");

	property p_enable;
		@(posedge clk) disable iff (rst)
		(amp_power_bypass_field == AMP_EN_ON) |=> (amp_powered && !amp_bypass);
	endproperty
	a_enable: assert property (p_enable) // [R3]
		else $error("amplifier not enabled on code 01");

	property p_split;
		@(posedge clk) disable iff (rst)
		((amp_power_bypass_field == AMP_EN_ON) && factor_code[2] && factor_code[1])
			|=> (amp_analog_code == 3'h5) && (amp_digital_shift == 2'($past(factor_code) - 3'h5));
	endproperty
	a_split: assert property (p_split) // [R5]
		else $error("high factor not split into analog 32 and digital");

	property p_no_shift_low;
		@(posedge clk) disable iff (rst)
		(factor_code <= 3'h5) |=> (amp_digital_shift == 2'h0) && (amp_analog_code == $past(factor_code));
	endproperty
	a_no_shift_low: assert property (p_no_shift_low) // [R1]
		else $error("low factor scaled digitally");

	property p_rail_gated;
		@(posedge clk) disable iff (rst)
		(!rail_detect_enable && !status_wr) |=> (rail_bus.flags == $past(rail_bus.flags));
	endproperty
	a_rail_gated: assert property (p_rail_gated) // [R7]
		else $error("rail flag raised while detection is off");

	property p_rail_raise;
		@(posedge clk) disable iff (rst)
		(rail_detect_enable && rail_near[0]) |=> fault_status[RAIL_FLAG_LSB]
			##1 (fault_status[RAIL_FLAG_LSB] || $past(status_wr && reg_wdata[RAIL_FLAG_LSB]));
	endproperty
	a_rail_raise: assert property (p_rail_raise) // [R6]
		else $error("rail flag not raised");

	property p_route_internal;
		@(posedge clk) disable iff (rst)
		(reference_control_q[VREF_SEL_LSB +: 2] == VREF_SEL_INTERNAL) |=> internal_vref_routed;
	endproperty
	a_route_internal: assert property (p_route_internal) // [R11]
		else $error("internal reference not routed on code 10");

	property p_vref_power;
		@(posedge clk) disable iff (rst)
		(internal_vref_power == VREF_PWR_SLEEPS) |=> (internal_vref_on == !$past(power_down));
	endproperty
	a_vref_power: assert property (p_vref_power) // [R12]
		else $error("sleeping reference mode wrong");

	property p_vref_off;
		@(posedge clk) disable iff (rst)
		(internal_vref_power == VREF_PWR_OFF) |=> !internal_vref_on;
	endproperty
	a_vref_off: assert property (p_vref_off) // [R12]
		else $error("reference on with power code 00");

	property p_sel_follow;
		@(posedge clk) disable iff (rst)
		##1 (vref_source_select == $past(reference_control_q[VREF_SEL_LSB +: 2]));
	endproperty
	a_sel_follow: assert property (p_sel_follow) // [R10]
		else $error("reference select does not follow register");
endmodule : amp_ref_config

/* core/amp_ref_pkg.sv */
// Constants for the amplifier and reference configuration block
package amp_ref_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFF_FAULT_STATUS     = 8'h01;
	localparam logic [7:0] OFF_AMP_SETTING      = 8'h03;
	localparam logic [7:0] OFF_REFERENCE_CTRL   = 8'h05;
	localparam logic [7:0] OFF_EXCITATION_ONE   = 8'h06;
	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_AMP_SETTING      = 8'h00;
	localparam logic [7:0] RST_REFERENCE_CTRL   = 8'h00;
	localparam logic [7:0] RST_EXCITATION_ONE   = 8'h00;
	// ==========================================================
	// Field positions
	localparam int         AMP_FACTOR_LSB       = 0;
	localparam int         AMP_EN_LSB           = 5;
	localparam int         VREF_POWER_LSB       = 0;
	localparam int         VREF_SEL_LSB         = 2;
	localparam int         RAIL_DET_BIT         = 7;
	localparam int         RAIL_FLAG_LSB        = 2;
	localparam int         VREF_FLAG_LSB        = 0;
	// ==========================================================
	// Field codes
	localparam logic [1:0] AMP_EN_BYPASS        = 2'h0;
	localparam logic [1:0] AMP_EN_ON            = 2'h1;
	localparam logic [1:0] VREF_SEL_PAIR0       = 2'h0;
	localparam logic [1:0] VREF_SEL_PAIR1       = 2'h1;
	localparam logic [1:0] VREF_SEL_INTERNAL    = 2'h2;
	localparam logic [1:0] VREF_PWR_OFF         = 2'h0;
	localparam logic [1:0] VREF_PWR_SLEEPS      = 2'h1;
	localparam logic [1:0] VREF_PWR_ALWAYS      = 2'h2;
	localparam logic [2:0] AMP_ANALOG_MAX_CODE  = 3'h5;
	localparam int         RAIL_FLAGS           = 4;
	localparam int         VREF_FLAGS           = 2;
endpackage : amp_ref_pkg

/* core/flag_if.sv */
// Set, clear and state of a group of sticky flags
`timescale 1ns/1ps
interface flag_if #(parameter int W = 4);
	logic [W-1:0] set;
	logic [W-1:0] clr;
	logic [W-1:0] flags;
	modport keeper (input set, input clr, output flags);
	modport user   (output set, output clr, input flags);
endinterface : flag_if

/* core/sticky_flags.sv */
// Sticky flag group where a set beats a clear in the same cycle
`timescale 1ns/1ps
module sticky_flags
	import amp_ref_pkg::*;
#(
	parameter int W = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Flag group
	flag_if.keeper   port
);
	generate
		if (W < 1) begin : g_bad_width
			$error("sticky_flags needs at least one flag");
		end
	endgenerate

	logic [W-1:0] flags_q;

	// ==========================================================
	// Flag storage
	// [R6] set wins clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flags_q <= '0;
		end else begin
			flags_q <= (flags_q & ~port.clr) | port.set;
		end
	end

	assign port.flags = flags_q;

	// ==========================================================
	// Checks
	property p_set_wins;
		@(posedge clk) disable iff (rst)
		(port.set != '0) |=> ((flags_q & $past(port.set)) == $past(port.set));
	endproperty
	a_set_wins: assert property (p_set_wins) // [R15]
		else $error("flag set in a clear cycle was lost");
endmodule : sticky_flags

/* sim/amp_and_reference_config_test.sv */
// Register-level bench for the amplifier and reference configuration block
`timescale 1ns/1ps
module amp_and_reference_config_test;
	import amp_ref_pkg::*;
	// ==========================================================
	// Signals
	logic       clk;
	logic       rst;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic       reg_rvalid;
	logic [3:0] rail_near;
	logic [1:0] vref_pair_low;
	logic       conversion_active;
	logic       power_down;
	logic       amp_powered;
	logic       amp_bypass;
	logic [7:0] amp_factor;
	logic [2:0] amp_analog_code;
	logic [1:0] amp_digital_shift;
	logic       rail_detect_on;
	logic [1:0] vref_source_select;
	logic       internal_vref_routed;
	logic       internal_vref_on;
	int         n_fail;
	int         check_count;
	int         cycles;
	// ==========================================================
	// Design
	amp_ref_config DUT (
		.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.rail_near(rail_near), .vref_pair_low(vref_pair_low),
		.conversion_active(conversion_active), .power_down(power_down),
		.amp_powered(amp_powered), .amp_bypass(amp_bypass),
		.amp_factor(amp_factor), .amp_analog_code(amp_analog_code),
		.amp_digital_shift(amp_digital_shift), .rail_detect_on(rail_detect_on),
		.vref_source_select(vref_source_select),
		.internal_vref_routed(internal_vref_routed),
		.internal_vref_on(internal_vref_on)
	);
	// ==========================================================
	// Clock and timeout
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			n_fail++;
			summarize();
		end
	end
	// ==========================================================
	// Tasks
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check({7'h00, reg_rvalid}, 8'h01, "read valid");
		check(reg_rdata, exp, what);
		@(posedge clk);
		#1;
		check({7'h00, reg_rvalid}, 8'h00, "valid pulse");
	endtask : rd
	task automatic pulse(input logic [3:0] r, input logic [1:0] v, input logic c);
		@(posedge clk);
		rail_near         <= r;
		vref_pair_low     <= v;
		conversion_active <= c;
		@(posedge clk);
		rail_near         <= 4'h0;
		vref_pair_low     <= 2'h0;
		conversion_active <= 1'b0;
	endtask : pulse
	function automatic logic [7:0] amp_bits();
		return {amp_powered, amp_bypass, amp_digital_shift, 1'b0, amp_analog_code};
	endfunction : amp_bits
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize
	// ==========================================================
	// Tests
	initial begin
		n_fail = 0;
		check_count = 0;
		cycles = 0;
		rst = 1'b1;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{rail_near, vref_pair_low, conversion_active, power_down} = '0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		#1;
		check(amp_bits(), 8'h40, "reset amp");
		check(amp_factor, 8'h01, "reset factor");
		check({internal_vref_on, internal_vref_routed, vref_source_select}, 8'h00, "reset ref");
		rd(OFF_FAULT_STATUS, 8'h00, "reset status");
		rd(OFF_AMP_SETTING, RST_AMP_SETTING, "reset amp reg");
		rd(OFF_REFERENCE_CTRL, RST_REFERENCE_CTRL, "reset ref reg");
		rd(OFF_EXCITATION_ONE, RST_EXCITATION_ONE, "reset exc reg");
		$display("test reset done");
		for (int n = 0; n < 8; n++) begin
			wr(OFF_AMP_SETTING, {1'b0, AMP_EN_ON, 2'b00, 3'(n)});
			check(amp_factor, 8'h01 << n, "factor");
			check(amp_bits(), {2'b10, 2'(n > 5 ? n - 5 : 0), 1'b0, 3'(n > 5 ? 5 : n)}, "split");
			rd(OFF_AMP_SETTING, {1'b0, AMP_EN_ON, 5'(n)}, "amp readback");
		end
		wr(OFF_AMP_SETTING, 8'h00);
		check(amp_bits(), 8'h40, "bypass");
		check(amp_factor, 8'h01, "bypass factor");
		$display("test amplifier done");
		for (int s = 0; s < 4; s++) begin
			for (int p = 0; p < 8; p++) begin
				@(posedge clk);
				power_down <= 1'(p / 4);
				wr(OFF_REFERENCE_CTRL, 8'(s * 4 + p % 4));
				check({internal_vref_on, internal_vref_routed, vref_source_select},
					{4'h0, 1'(p % 4 == 2 || p == 1), 1'(s == 2), 2'(s)}, "ref decode");
				rd(OFF_REFERENCE_CTRL, 8'(s * 4 + p % 4), "ref readback");
			end
		end
		power_down <= 1'b0;
		$display("test reference done");
		pulse(4'hf, 2'h0, 1'b0);
		rd(OFF_FAULT_STATUS, 8'h00, "rail gated");
		wr(OFF_EXCITATION_ONE, 8'h80);
		check({7'h00, rail_detect_on}, 8'h01, "detect on");
		pulse(4'ha, 2'h0, 1'b0);
		rd(OFF_FAULT_STATUS, 8'h28, "rail set");
		rd(OFF_FAULT_STATUS, 8'h28, "rail sticky");
		wr(OFF_FAULT_STATUS, 8'h28);
		rd(OFF_FAULT_STATUS, 8'h00, "rail clear");
		pulse(4'h5, 2'h0, 1'b0);
		rd(OFF_FAULT_STATUS, 8'h14, "rail other");
		wr(OFF_FAULT_STATUS, 8'hff);
		pulse(4'h0, 2'h3, 1'b0);
		rd(OFF_FAULT_STATUS, 8'h00, "ref gated");
		pulse(4'h0, 2'h2, 1'b1);
		rd(OFF_FAULT_STATUS, 8'h02, "ref pair one");
		pulse(4'h0, 2'h1, 1'b1);
		rd(OFF_FAULT_STATUS, 8'h03, "ref both");
		$display("test flags done");
		wr(8'h02, 8'hff);
		rd(8'h02, 8'h00, "unmapped");
		rd(OFF_AMP_SETTING, 8'h00, "unmapped no effect");
		$display("test unmapped done");
		summarize();
	end
endmodule : amp_and_reference_config_test
